// file: src/fsp_core.sv
`timescale 1ns/1ps
`default_nettype none

module fsp_core #(
  parameter int unsigned PAGE_WRITE_CYC   = fsp_pkg::PAGE_WRITE_CYC,
  parameter int unsigned SECTOR_CLEAR_CYC = fsp_pkg::SECTOR_CLEAR_CYC
) (
  input  wire logic                 CLK,
  input  wire logic                 RESET,
  input  wire logic                 CS_N,
  input  wire logic                 SCLK,
  input  wire logic [3:0]           IO_IN,
  output logic [3:0]                IO_OUT,
  output logic [3:0]                IO_OE,
  input  wire logic [4:0]           PROTECT_BITS,
  input  wire logic                 WRAP_EN,
  input  wire logic [1:0]           WRAP_LEN,
  output logic [31:0]               MEM_RD_ADDR,
  input  wire logic [7:0]           MEM_RD_DATA,
  output fsp_pkg::fsp_mem_req_t     MEM_REQ,
  output logic                      WRITE_UNLOCK_LATCH,
  output logic                      OPERATION_PENDING_FLAG,
  output logic                      FOUR_BYTE_MODE
);

  typedef struct packed {
    logic                  cs_s1;
    logic                  cs_s2;
    logic                  cs_d;
    logic                  ck_s1;
    logic                  ck_s2;
    logic                  ck_d;
    logic [3:0]            io_s1;
    logic [3:0]            io_s2;
    fsp_pkg::fsp_phase_t   phase;
    fsp_pkg::fsp_op_t      op;
    fsp_pkg::fsp_busy_t    busy;
    logic                  aq;
    logic                  dq;
    logic [7:0]            sh;
    logic [2:0]            bcnt;
    logic [1:0]            acnt;
    logic                  data_seen;
    logic [31:0]           addr;
    logic [7:0]            ptr;
    logic [255:0]          mask;
    logic [255:0][7:0]     pdata;
    logic                  write_unlock_latch;
    logic                  four_b;
    logic [8:0]            idx;
    logic [23:0]           timer;
    logic [7:0]            osh;
    logic [2:0]            obit;
    logic                  so;
    logic                  so_oe;
    fsp_pkg::fsp_mem_req_t mem_req;
  } fsp_state_t;

  fsp_state_t  st_r;
  fsp_state_t  st_nxt;
  logic        ck_rise;
  logic        ck_fall;
  logic        cs_fall;
  logic        cs_rise;
  logic        sel;
  logic        quad_now;
  logic        byte_done;
  logic        aligned;
  logic        prot_hit;
  logic        operation_pending_flag;
  logic [7:0]  sh_new;
  logic [7:0]  out_byte;
  logic [1:0]  wlen;
  logic [31:0] wmask;
  logic [31:0] nxt_rd;
  logic        mask_at_idx;
  logic [25:0] addr_hi;

  // Protection is judged on the latched target address
  fsp_protect u_prot (
    .addr (st_r.addr),
    .bp   (PROTECT_BITS),
    .hit  (prot_hit)
  );

  assign operation_pending_flag         = (st_r.busy != fsp_pkg::BS_IDLE);
  assign mask_at_idx = st_r.mask[st_r.idx[7:0]];
  assign addr_hi     = st_r.addr[31:6];

  // Edge finding works only on the second synchroniser stage
  always_comb begin
    ck_rise  = st_r.ck_s2 & ~st_r.ck_d;
    ck_fall  = ~st_r.ck_s2 & st_r.ck_d;
    cs_fall  = ~st_r.cs_s2 & st_r.cs_d;
    cs_rise  = st_r.cs_s2 & ~st_r.cs_d;
    sel      = ~st_r.cs_s2;
    quad_now = ((st_r.phase == fsp_pkg::PH_ADDR) && st_r.aq) ||
               ((st_r.phase == fsp_pkg::PH_DATA) && st_r.dq);
    sh_new   = quad_now ? {st_r.sh[3:0], st_r.io_s2} : {st_r.sh[6:0], st_r.io_s2[0]};
    byte_done = ck_rise && sel && (quad_now ? (st_r.bcnt == 3'h1) : (st_r.bcnt == 3'h7))
                && ((st_r.phase == fsp_pkg::PH_OPC) || (st_r.phase == fsp_pkg::PH_ADDR)
                    || (st_r.phase == fsp_pkg::PH_DATA));
    aligned  = (st_r.bcnt == 3'h0);
    out_byte = (st_r.op == fsp_pkg::OP_STATUS) ? {6'h00, st_r.write_unlock_latch, operation_pending_flag} : MEM_RD_DATA;
    wlen     = (WRAP_LEN > fsp_pkg::WRAP_LEN_MAX) ? fsp_pkg::WRAP_LEN_MAX : WRAP_LEN;
    wmask    = {26'h0, (fsp_pkg::WRAP_BASE_MASK << wlen) | fsp_pkg::WRAP_BASE_MASK};
    nxt_rd   = WRAP_EN ? ((st_r.addr & ~wmask) | ((st_r.addr + 32'h1) & wmask))
                       : (st_r.addr + 32'h1);
  end

  // Next-state logic: serial front end, command commit and self-timed cycle
  always_comb begin
    st_nxt               = st_r;
    st_nxt.mem_req.wr    = 1'b0;
    st_nxt.mem_req.erase = 1'b0;
    st_nxt.cs_s1         = CS_N;
    st_nxt.cs_s2         = st_r.cs_s1;
    st_nxt.cs_d          = st_r.cs_s2;
    st_nxt.ck_s1         = SCLK;
    st_nxt.ck_s2         = st_r.ck_s1;
    st_nxt.ck_d          = st_r.ck_s2;
    st_nxt.io_s1         = IO_IN;
    st_nxt.io_s2         = st_r.io_s1;

    // Self-timed cycle; the timer must outlast the 256-step write walk
    if (operation_pending_flag) begin
      st_nxt.timer = st_r.timer - 24'h1;
      if ((st_r.busy == fsp_pkg::BS_PROG) && !st_r.idx[8]) begin
        st_nxt.idx = st_r.idx + 9'h1;
        if (mask_at_idx) begin
          st_nxt.mem_req.wr    = 1'b1;
          st_nxt.mem_req.addr  = {st_r.addr[31:8], st_r.idx[7:0]};
          st_nxt.mem_req.wdata = st_r.pdata[st_r.idx[7:0]];
        end
      end
      if (st_r.timer == 24'h1) begin
        st_nxt.busy = fsp_pkg::BS_IDLE;
      end
    end

    if (cs_fall) begin
      st_nxt.phase     = fsp_pkg::PH_OPC;
      st_nxt.bcnt      = 3'h0;
      st_nxt.data_seen = 1'b0;
      st_nxt.obit      = 3'h0;
      st_nxt.op        = fsp_pkg::OP_NONE;
    end else if (cs_rise) begin
      // Commit only on a byte boundary, so a partial byte voids the command
      case (st_r.op)
        fsp_pkg::OP_PROG: begin
          if ((st_r.phase == fsp_pkg::PH_DATA) && aligned && st_r.data_seen
              && st_r.write_unlock_latch && !prot_hit && !operation_pending_flag) begin
            st_nxt.busy  = fsp_pkg::BS_PROG;
            st_nxt.write_unlock_latch   = 1'b0;
            st_nxt.idx   = 9'h0;
            st_nxt.timer = 24'(PAGE_WRITE_CYC);
          end
        end
        fsp_pkg::OP_ERASE: begin
          if ((st_r.phase == fsp_pkg::PH_DATA) && aligned && !st_r.data_seen
              && st_r.write_unlock_latch && !prot_hit && !operation_pending_flag) begin
            st_nxt.busy          = fsp_pkg::BS_ERASE;
            st_nxt.write_unlock_latch           = 1'b0;
            st_nxt.timer         = 24'(SECTOR_CLEAR_CYC);
            st_nxt.mem_req.erase = 1'b1;
            st_nxt.mem_req.addr  = st_r.addr & ~{20'h0, fsp_pkg::SECTOR_OFS_MASK};
          end
        end
        fsp_pkg::OP_UNLOCK: begin
          if ((st_r.phase == fsp_pkg::PH_DATA) && aligned && !st_r.data_seen) begin
            st_nxt.write_unlock_latch = 1'b1;
          end
        end
        fsp_pkg::OP_LOCK: begin
          if ((st_r.phase == fsp_pkg::PH_DATA) && aligned && !st_r.data_seen) begin
            st_nxt.write_unlock_latch = 1'b0;
          end
        end
        fsp_pkg::OP_EN4B: begin
          if ((st_r.phase == fsp_pkg::PH_DATA) && aligned && !st_r.data_seen) begin
            st_nxt.four_b = 1'b1;
          end
        end
        fsp_pkg::OP_EX4B: begin
          if ((st_r.phase == fsp_pkg::PH_DATA) && aligned && !st_r.data_seen) begin
            st_nxt.four_b = 1'b0;
          end
        end
        default: begin
        end
      endcase
      st_nxt.phase = fsp_pkg::PH_SKIP;
      st_nxt.so_oe = 1'b0;
    end else if (ck_rise && sel && ((st_r.phase == fsp_pkg::PH_OPC) ||
                 (st_r.phase == fsp_pkg::PH_ADDR) || (st_r.phase == fsp_pkg::PH_DATA))) begin
      st_nxt.sh   = sh_new;
      st_nxt.bcnt = byte_done ? 3'h0 : (st_r.bcnt + 3'h1);
      if (byte_done) begin
        case (st_r.phase)
          fsp_pkg::PH_OPC: begin
            st_nxt.op   = fsp_pkg::fsp_decode(sh_new);
            st_nxt.aq   = (sh_new == fsp_pkg::OPC_EXT_QUAD_3B) ||
                          (sh_new == fsp_pkg::OPC_EXT_QUAD_4B);
            st_nxt.dq   = st_nxt.aq || (sh_new == fsp_pkg::OPC_QUAD_WRITE_3B) ||
                          (sh_new == fsp_pkg::OPC_QUAD_WRITE_4B);
            // A busy cycle still walks its page, so a refused frame keeps the address
            if (!operation_pending_flag) begin
              st_nxt.addr = 32'h0;
            end
            st_nxt.acnt = (st_r.four_b || fsp_pkg::fsp_is_4b(sh_new)) ? 2'h3 : 2'h2;
            if (operation_pending_flag && (st_nxt.op != fsp_pkg::OP_STATUS)) begin
              st_nxt.phase = fsp_pkg::PH_SKIP;
            end else begin
              case (st_nxt.op)
                fsp_pkg::OP_PROG, fsp_pkg::OP_ERASE, fsp_pkg::OP_READ: begin
                  st_nxt.phase = fsp_pkg::PH_ADDR;
                end
                fsp_pkg::OP_STATUS: begin
                  st_nxt.phase = fsp_pkg::PH_OUT;
                end
                fsp_pkg::OP_NONE: begin
                  st_nxt.phase = fsp_pkg::PH_SKIP;
                end
                default: begin
                  st_nxt.phase = fsp_pkg::PH_DATA;
                end
              endcase
            end
            if (st_nxt.op == fsp_pkg::OP_PROG && !operation_pending_flag) begin
              st_nxt.mask = 256'h0;
            end
          end
          fsp_pkg::PH_ADDR: begin
            st_nxt.addr = {st_r.addr[23:0], sh_new};
            st_nxt.ptr  = sh_new;
            if (st_r.acnt == 2'h0) begin
              st_nxt.phase = (st_r.op == fsp_pkg::OP_READ) ? fsp_pkg::PH_OUT
                                                           : fsp_pkg::PH_DATA;
            end else begin
              st_nxt.acnt = st_r.acnt - 2'h1;
            end
          end
          default: begin
            st_nxt.data_seen = 1'b1;
            if (st_r.op == fsp_pkg::OP_PROG) begin
              // Later bytes overwrite earlier ones at the same slot
              st_nxt.pdata[st_r.ptr] = sh_new;
              st_nxt.mask[st_r.ptr]  = 1'b1;
              st_nxt.ptr             = st_r.ptr + 8'h1;
            end
          end
        endcase
      end
    end else if (ck_fall && sel && (st_r.phase == fsp_pkg::PH_OUT)) begin
      // Output shifts on falling edges, most significant bit first
      st_nxt.so_oe = 1'b1;
      st_nxt.obit  = st_r.obit + 3'h1;
      if (st_r.obit == 3'h0) begin
        st_nxt.so  = out_byte[7];
        st_nxt.osh = {out_byte[6:0], 1'b0};
        if (st_r.op == fsp_pkg::OP_READ) begin
          st_nxt.addr = nxt_rd;
        end
      end else begin
        st_nxt.so  = st_r.osh[7];
        st_nxt.osh = {st_r.osh[6:0], 1'b0};
      end
    end
  end

  // State register; reset loads constants only
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st_r        <= '0;
      st_r.cs_s1  <= fsp_pkg::CS_IDLE;
      st_r.cs_s2  <= fsp_pkg::CS_IDLE;
      st_r.cs_d   <= fsp_pkg::CS_IDLE;
      st_r.phase  <= fsp_pkg::PH_SKIP;
      st_r.op     <= fsp_pkg::OP_NONE;
      st_r.busy   <= fsp_pkg::BS_IDLE;
      st_r.write_unlock_latch    <= fsp_pkg::UNLOCK_RST;
      st_r.four_b <= fsp_pkg::FOUR_B_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Single-line answers leave on IO1; other lines stay released
  assign IO_OUT                 = {2'h0, st_r.so, 1'b0};
  assign IO_OE                  = {2'h0, st_r.so_oe, 1'b0};
  assign MEM_RD_ADDR            = st_r.addr;
  assign MEM_REQ                = st_r.mem_req;
  assign WRITE_UNLOCK_LATCH     = st_r.write_unlock_latch;
  assign OPERATION_PENDING_FLAG = operation_pending_flag;
  assign FOUR_BYTE_MODE         = st_r.four_b;

  default clocking dck @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence prog_commit_s;
    cs_rise && (st_r.op == fsp_pkg::OP_PROG) && (st_r.phase == fsp_pkg::PH_DATA) && aligned
      && st_r.data_seen && st_r.write_unlock_latch && !prot_hit && !operation_pending_flag;
  endsequence

  sequence prog_cycle_s;
    (st_r.busy == fsp_pkg::BS_PROG) && (st_r.timer == 24'(PAGE_WRITE_CYC)) && !st_r.write_unlock_latch;
  endsequence

  AST_UNLOCK_FIRST: assert property ($rose(operation_pending_flag) |-> $past(st_r.write_unlock_latch))
    else $error("cycle started without write unlock");
  AST_UNLOCK_DROPS: assert property ($rose(operation_pending_flag) |-> !st_r.write_unlock_latch ##1 !st_r.write_unlock_latch)
    else $error("unlock latch not cleared at cycle start");
  AST_PROG_COMMIT: assert property (prog_commit_s |=> prog_cycle_s)
    else $error("valid program did not start its cycle");
  AST_PROG_PARTIAL: assert property (
      (cs_rise && (st_r.op == fsp_pkg::OP_PROG) && !aligned && !operation_pending_flag) |=> !operation_pending_flag)
    else $error("misaligned program was executed");
  AST_PROTECT: assert property ((cs_rise && prot_hit && !operation_pending_flag) |=> !operation_pending_flag [*2])
    else $error("protected target started a cycle");
  AST_PTR_STEP: assert property (
      (byte_done && (st_r.phase == fsp_pkg::PH_DATA) && (st_r.op == fsp_pkg::OP_PROG))
      |=> (st_r.ptr == $past(st_r.ptr) + 8'h1) && (addr_hi == $past(addr_hi)))
    else $error("byte pointer did not step within page");
  AST_ERASE_BASE: assert property (st_r.mem_req.erase |-> (st_r.mem_req.addr[11:0] == 12'h0)
      && (st_r.busy == fsp_pkg::BS_ERASE) && (st_r.timer == 24'(SECTOR_CLEAR_CYC)))
    else $error("sector clear request malformed");
  AST_BUSY_FLAG: assert property ((st_r.timer > 24'h1) |=> OPERATION_PENDING_FLAG)
    else $error("pending flag dropped before timer expiry");
  AST_READ_REJECT: assert property (
      (operation_pending_flag && (st_r.op == fsp_pkg::OP_READ)) |-> (st_r.phase != fsp_pkg::PH_OUT))
    else $error("read served during busy cycle");
  AST_WRITE_MASK: assert property (st_r.mem_req.wr |-> $past(mask_at_idx))
    else $error("unaddressed page byte written");
  AST_WRAP_READ: assert property (
      (ck_fall && sel && (st_r.phase == fsp_pkg::PH_OUT) && (st_r.op == fsp_pkg::OP_READ)
       && (st_r.obit == 3'h0) && WRAP_EN) |=> (addr_hi == $past(addr_hi)))
    else $error("wrapped read left its section");

endmodule : fsp_core

`default_nettype wire

// file: src/fsp_pkg.sv
package fsp_pkg;

  // System clock rate and self-timed cycle lengths
  localparam int unsigned CLK_MHZ                  = 25;
  localparam int unsigned PAGE_WRITE_DURATION_US   = 700;
  localparam int unsigned SECTOR_CLEAR_DURATION_US = 45000;
  localparam int unsigned PAGE_WRITE_CYC   = PAGE_WRITE_DURATION_US * CLK_MHZ;
  localparam int unsigned SECTOR_CLEAR_CYC = SECTOR_CLEAR_DURATION_US * CLK_MHZ;

  // Command codes
  localparam logic [7:0] OPC_PAGE_WRITE_3B  = 8'h02;
  localparam logic [7:0] OPC_PAGE_WRITE_4B  = 8'h12;
  localparam logic [7:0] OPC_QUAD_WRITE_3B  = 8'h32;
  localparam logic [7:0] OPC_QUAD_WRITE_4B  = 8'h34;
  localparam logic [7:0] OPC_EXT_QUAD_3B    = 8'hc2;
  localparam logic [7:0] OPC_EXT_QUAD_4B    = 8'h3e;
  localparam logic [7:0] OPC_SECTOR_CLR_3B  = 8'h20;
  localparam logic [7:0] OPC_SECTOR_CLR_4B  = 8'h21;
  localparam logic [7:0] OPC_READ_3B        = 8'h03;
  localparam logic [7:0] OPC_READ_4B        = 8'h13;
  localparam logic [7:0] OPC_STATUS         = 8'h05;
  localparam logic [7:0] OPC_WRITE_UNLOCK   = 8'h06;
  localparam logic [7:0] OPC_WRITE_LOCK     = 8'h04;
  localparam logic [7:0] OPC_ENTER_4B       = 8'hb7;
  localparam logic [7:0] OPC_EXIT_4B        = 8'he9;

  // Field positions and geometry
  localparam logic [11:0] SECTOR_OFS_MASK = 12'hfff;
  localparam logic [4:0]  PROT_UNIT_BITS  = 5'h10;
  localparam logic [4:0]  ARRAY_BITS      = 5'h1a;
  localparam logic [5:0]  WRAP_BASE_MASK  = 6'h0f;
  localparam logic [1:0]  WRAP_LEN_MAX    = 2'h2;

  // Reset values
  localparam logic        UNLOCK_RST  = 1'h0;
  localparam logic        FOUR_B_RST  = 1'h0;
  localparam logic        CS_IDLE     = 1'h1;

  typedef enum logic [4:0] {
    PH_OPC  = 5'b00001,
    PH_ADDR = 5'b00010,
    PH_DATA = 5'b00100,
    PH_OUT  = 5'b01000,
    PH_SKIP = 5'b10000
  } fsp_phase_t;

  typedef enum logic [8:0] {
    OP_NONE   = 9'b000000001,
    OP_PROG   = 9'b000000010,
    OP_ERASE  = 9'b000000100,
    OP_READ   = 9'b000001000,
    OP_STATUS = 9'b000010000,
    OP_UNLOCK = 9'b000100000,
    OP_LOCK   = 9'b001000000,
    OP_EN4B   = 9'b010000000,
    OP_EX4B   = 9'b100000000
  } fsp_op_t;

  typedef enum logic [2:0] {
    BS_IDLE  = 3'b001,
    BS_PROG  = 3'b010,
    BS_ERASE = 3'b100
  } fsp_busy_t;

  // Request toward the storage array
  typedef struct packed {
    logic        wr;
    logic        erase;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } fsp_mem_req_t;

  function automatic fsp_op_t fsp_decode(input logic [7:0] c);
    case (c)
      OPC_PAGE_WRITE_3B, OPC_PAGE_WRITE_4B, OPC_QUAD_WRITE_3B,
      OPC_QUAD_WRITE_4B, OPC_EXT_QUAD_3B, OPC_EXT_QUAD_4B: return OP_PROG;
      OPC_SECTOR_CLR_3B, OPC_SECTOR_CLR_4B:               return OP_ERASE;
      OPC_READ_3B, OPC_READ_4B:                           return OP_READ;
      OPC_STATUS:                                         return OP_STATUS;
      OPC_WRITE_UNLOCK:                                   return OP_UNLOCK;
      OPC_WRITE_LOCK:                                     return OP_LOCK;
      OPC_ENTER_4B:                                       return OP_EN4B;
      OPC_EXIT_4B:                                        return OP_EX4B;
      default:                                            return OP_NONE;
    endcase
  endfunction : fsp_decode

  // Codes that always carry a four-byte address
  function automatic logic fsp_is_4b(input logic [7:0] c);
    return (c == OPC_PAGE_WRITE_4B) || (c == OPC_QUAD_WRITE_4B) ||
           (c == OPC_EXT_QUAD_4B) || (c == OPC_SECTOR_CLR_4B) || (c == OPC_READ_4B);
  endfunction : fsp_is_4b

endpackage : fsp_pkg

// file: src/fsp_protect.sv
`timescale 1ns/1ps
`default_nettype none

// Protected-region check: protect_bit_0..3 set the size, protect_bit_4 picks the bottom
module fsp_protect (
  input  wire logic [31:0] addr,
  input  wire logic [4:0]  bp,
  output logic             hit
);

  logic [4:0]  span;
  logic [25:0] m;

  // Region is 64KB << (level-1); anything at or above the array size covers it all
  always_comb begin
    span = fsp_pkg::PROT_UNIT_BITS + {1'b0, bp[3:0]} - 5'h1;
    if (span >= fsp_pkg::ARRAY_BITS) begin
      m = 26'h0;
    end else begin
      m = ~((26'h1 << span) - 26'h1);
    end
    if (bp[3:0] == 4'h0) begin
      hit = 1'b0;
    end else if (bp[4]) begin
      hit = ((addr[25:0] & m) == 26'h0);
    end else begin
      hit = ((addr[25:0] & m) == m);
    end
  end

endmodule : fsp_protect

`default_nettype wire

// file: tb/fsp_host.sv
`timescale 1ns/1ps
`default_nettype none

// Host end of the serial link; SCLK stands low outside frames
module fsp_host (
  input  wire logic  clk,
  output logic       cs_n,
  output logic       sclk,
  output logic [3:0] io,
  input  wire logic  so
);
  // Idle levels at time zero
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io   = 4'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Select falls and stays low for the whole frame
  task automatic sel();
    tick(1);
    cs_n <= 1'b0;
    tick(4);
  endtask : sel

  // Select rises after the last complete step; released lines flip so no stale value
  task automatic desel();
    tick(4);
    cs_n <= 1'b1;
    io   <= ~io;
    tick(8);
  endtask : desel

  // MSB first; quad sends the high nibble first on IO3..IO0
  task automatic xb(input logic [7:0] b, input bit q, input int nb, output logic [7:0] r);
    for (int i = 0; i < nb; i++) begin
      if (q)
        io <= (i == 0) ? b[7:4] : b[3:0];
      else
        io <= {3'h0, b[7 - i]};
      tick(4);
      sclk <= 1'b1;
      tick(4);
      r = {r[6:0], so}; // Late sample avoids the 3-4 CLK output lag
      sclk <= 1'b0;
    end
  endtask : xb
endmodule : fsp_host

`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int PW = 400;
  localparam int SC = 300;
  logic                  clk = 1'b0;
  logic                  reset = 1'b1;
  logic                  cs_n;
  logic                  sclk;
  logic [3:0]            io_in;
  logic [3:0]            io_out;
  logic [4:0]            prot = 5'h00;
  logic                  wrap_en = 1'b0;
  logic [1:0]            wrap_len = 2'h0;
  logic [3:0]            oe;
  logic [31:0]           wr_addr;
  logic [31:0]           rd_addr;
  fsp_pkg::fsp_mem_req_t req;
  logic                  latch;
  logic                  pend;
  logic                  fourb;
  logic [7:0]            arr [0:255];
  logic [31:0]           er_addr;
  logic [7:0]            r;
  int                    n_errors = 0;
  int                    cmp_count = 0;
  int                    cyc = 0;
  int                    n_wr = 0;
  int                    n_er = 0;

  always #20 clk = ~clk;

  fsp_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .io(io_in), .so(io_out[1]));

  fsp_core #(.PAGE_WRITE_CYC(PW), .SECTOR_CLEAR_CYC(SC)) uut (
    .CLK(clk), .RESET(reset), .CS_N(cs_n), .SCLK(sclk), .IO_IN(io_in),
    .IO_OUT(io_out), .IO_OE(oe), .PROTECT_BITS(prot), .WRAP_EN(wrap_en),
    .WRAP_LEN(wrap_len), .MEM_RD_ADDR(rd_addr), .MEM_RD_DATA(arr[rd_addr[7:0]]),
    .MEM_REQ(req), .WRITE_UNLOCK_LATCH(latch), .OPERATION_PENDING_FLAG(pend),
    .FOUR_BYTE_MODE(fourb));

  // Array model keeps one page only; the full write address is kept for page checks
  // The run needs about 12000 cycles, so 20000 means a hang
  always @(posedge clk) begin
    cyc++;
    if (req.wr === 1'b1) begin
      arr[req.addr[7:0]] = req.wdata;
      wr_addr = req.addr;
      n_wr++;
    end
    if (req.erase === 1'b1) begin
      er_addr = req.addr;
      n_er++;
    end
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic end_of_test();
    $display("errors %0d, comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  task automatic cmd1(input logic [7:0] c);
    host.sel();
    host.xb(c, 0, 8, r);
    host.desel();
  endtask : cmd1

  // Opcode, three address bytes, n data bytes, then cut extra steps
  task automatic send(input logic [7:0] opc, input bit qa, input bit qd,
                      input logic [23:0] a, input int n, input int cut);
    n_wr = 0;
    n_er = 0;
    host.sel();
    host.xb(opc, 0, 8, r);
    for (int i = 2; i >= 0; i--)
      host.xb(a[8*i +: 8], qa, qa ? 2 : 8, r);
    for (int i = 0; i < n; i++)
      host.xb(8'(i) + 8'(i / 256) + 8'h40, qd, qd ? 2 : 8, r);
    if (cut > 0)
      host.xb(8'h5a, 0, cut, r);
    host.desel();
  endtask : send

  task automatic idle(input int lim, output int c);
    c = 0;
    while (pend !== 1'b0 && c < lim) begin
      @(posedge clk);
      c++;
    end
    chk(pend, 1'b0, "cycle never ended");
  endtask : idle

  task automatic s_refuse();
    send(8'h02, 0, 0, 24'h000100, 1, 0);
    host.tick(20);
    chk(n_wr, 0, "program without unlock");
    cmd1(8'h06);
    send(8'h02, 0, 0, 24'h000020, 1, 4);
    host.tick(20);
    chk(n_wr, 0, "program cut mid-byte");
    chk(pend, 1'b0, "busy after cut");
    $display("refuse test done");
  endtask : s_refuse

  task automatic s_prog();
    int c0;
    int c;
    logic [7:0] s;
    cmd1(8'h06);
    chk(latch, 1'b1, "unlock latch");
    send(8'h02, 0, 0, 24'h0012fe, 3, 0);
    c0 = cyc;
    host.tick(5);
    chk(pend, 1'b1, "pending after program");
    chk(latch, 1'b0, "latch kept");
    cmd1(8'h05);
    host.sel();
    host.xb(8'h05, 0, 8, r);
    host.xb(8'h00, 0, 8, s);
    host.desel();
    chk(s, 8'h01, "status during busy");
    idle(PW + 100, c);
    chk((cyc - c0 >= PW - 8) && (cyc - c0 <= PW + 4), 1, "busy length");
    chk(arr[8'hfe], 8'h40, "first byte");
    chk(arr[8'hff], 8'h41, "page end byte");
    chk(arr[8'h00], 8'h42, "wrapped byte");
    chk(arr[8'h01], 8'h00, "untouched byte");
    chk(n_wr, 3, "write count");
    chk(wr_addr, 32'h000012ff, "page lost during status read");
    $display("program test done");
  endtask : s_prog

  task automatic s_quad();
    logic [7:0] op [2] = '{8'h32, 8'hc2};
    int c;
    for (int i = 0; i < 2; i++) begin
      arr[8'h10] = 8'h00;
      arr[8'h11] = 8'h00;
      cmd1(8'h06);
      send(op[i], op[i] == 8'hc2, 1, 24'h000210, 2, 0);
      idle(PW + 100, c);
      chk(n_wr, 2, "quad write count");
      chk(arr[8'h10], 8'h40, "quad first byte");
      chk(arr[8'h11], 8'h41, "quad second byte");
    end
    // 257 bytes from slot 0: the last one lands on slot 0 again
    cmd1(8'h06);
    send(8'h32, 0, 1, 24'h000300, 257, 0);
    idle(PW + 100, c);
    chk(n_wr, 256, "over-length write count");
    chk(arr[8'h00], 8'h41, "last byte wins");
    chk(arr[8'h02], 8'h42, "over-length kept byte");
    $display("quad test done");
  endtask : s_quad

  task automatic s_erase();
    int c;
    cmd1(8'h06);
    send(8'h20, 0, 0, 24'h001234, 0, 0);
    host.tick(2);
    chk(n_er, 1, "erase pulse");
    chk(er_addr, 32'h00001000, "sector base");
    chk(pend, 1'b1, "pending in erase");
    idle(SC + 100, c);
    chk(pend, 1'b0, "erase end");
    cmd1(8'h06);
    send(8'h20, 0, 0, 24'h001234, 1, 0);
    host.tick(20);
    chk(n_er, 0, "erase with extra byte");
    $display("erase test done");
  endtask : s_erase

  task automatic s_prot();
    @(posedge clk);
    prot <= 5'h11;
    cmd1(8'h06);
    send(8'h02, 0, 0, 24'h000010, 1, 0);
    host.tick(20);
    chk(n_wr, 0, "protected program");
    send(8'h20, 0, 0, 24'h000010, 0, 0);
    host.tick(20);
    chk(n_er, 0, "protected erase");
    prot <= 5'h00;
    $display("protect test done");
  endtask : s_prot

  // Read during a busy cycle is refused; then a wrapped read in four-byte mode
  task automatic s_read();
    int c;
    logic [7:0] s;
    for (int i = 0; i < 32; i++)
      arr[i] = 8'h80 + 8'(i);
    cmd1(8'h06);
    send(8'h02, 0, 0, 24'h000180, 1, 0);
    host.sel();
    host.xb(8'h03, 0, 8, r);
    for (int i = 0; i < 4; i++)
      host.xb(8'h00, 0, 8, s);
    chk(oe[1], 1'b0, "read answered while busy");
    host.desel();
    chk(pend, 1'b1, "busy cut by read");
    idle(PW + 100, c);
    chk(wr_addr, 32'h00000180, "busy target moved");
    chk(arr[8'h80], 8'h40, "busy write lost");
    wrap_en  <= 1'b1;
    wrap_len <= 2'h1;
    cmd1(8'hb7);
    chk(fourb, 1'b1, "four-byte mode on");
    host.sel();
    host.xb(8'h03, 0, 8, r);
    for (int i = 0; i < 3; i++)
      host.xb(8'h00, 0, 8, r);
    host.xb(8'h1e, 0, 8, r);
    for (int i = 0; i < 4; i++) begin
      host.xb(8'h00, 0, 8, s);
      chk(s, 8'h80 + 8'((i + 30) % 32), "wrapped read byte");
    end
    chk(oe[1], 1'b1, "read output enable");
    host.desel();
    chk(oe, 4'h0, "output released");
    cmd1(8'he9);
    chk(fourb, 1'b0, "four-byte mode off");
    wrap_en <= 1'b0;
    $display("read test done");
  endtask : s_read

  // Main sequence
  initial begin
    for (int i = 0; i < 256; i++)
      arr[i] = 8'h00;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk(fourb, 1'b0, "address mode");
    s_refuse();
    s_prog();
    s_quad();
    s_erase();
    s_prot();
    s_read();
    end_of_test();
  end
endmodule : testbench

`default_nettype wire
